/* File: verilog/hoec_cmd.sv */
// Device-side command interpreter for health monitoring commands
`timescale 1ns/1ps
`default_nettype none
`include "hoec_cfg.svh"

// Functional notes
// - Enable state kept in non-volatile store
// - No data gathered before enable command
// - Repeat enable leaves monitoring data untouched
// - B0h with feature D4h runs routine
// - Subcommand byte selects the routine
// - Non-data protocol, no data words
// - Captive pass returns 4Fh/C2h signature
// - Success clears busy, fault, request, error
// - Abort if unsupported, disabled or bad signature
// - Captive failure returns F4h/2Ch, aborts
// - Other captive aborts return 4Fh/C2h
// - Off-line errors leave signature undefined
// - Sector-not-found flag on missing ID field
// - Aborted-command flag for aborts, captive failures
// - Error end sets ready and error flag; fault only from engine fault
// - Device-select bit picks addressed drive
// - Codes 0,1,2,127,129,130 select routines
// - Captive mode holds busy during test
// - Off-line mode completes before routine runs
// - New command stops off-line routine in time
module hoec_cmd
  import hoec_pkg::*;
#(
  parameter int SERVICE_CYC = `HOEC_SERVICE_CYC
) (
  input  wire logic       CLK,
  input  wire logic       SRST,
  input  wire logic       CE,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output var  logic [7:0] RDATA,
  input  wire logic       DRIVE_ID,
  input  wire logic       NV_ENABLE,
  output var  logic       NV_WRITE,
  output var  logic       NV_VALUE,
  output var  logic       ROUTINE_START,
  output var  logic [7:0] ROUTINE_CODE,
  output var  logic       ROUTINE_STOP,
  output var  logic       ROUTINE_ACTIVE,
  output var  logic       MONITOR_ON,
  input  wire logic       ROUTINE_DONE,
  input  wire logic       ROUTINE_FAIL,
  input  wire logic       ROUTINE_SECTOR_NOT_FOUND_FLAG,
  input  wire logic       ROUTINE_FAULT
);

  // ==========================================
  // Pin synchronisers for the routine engine and straps
  logic [5:0] sync_a;                  // First stage
  logic [5:0] sync_b;                  // Second stage, read by logic
  // No reset here: the stages fill with live pin levels during reset,
  // so the stored enable is already valid on the first edge after it
  always_ff @(posedge CLK) begin
    if (CE) begin
      sync_a <= {NV_ENABLE, DRIVE_ID, ROUTINE_DONE, ROUTINE_FAIL, ROUTINE_SECTOR_NOT_FOUND_FLAG, ROUTINE_FAULT};
      sync_b <= sync_a;
    end
  end
  logic nv_en_s;                       // Stored enable level
  logic drive_id_s;                    // Our drive number
  logic r_done;                        // Routine finished
  logic r_fail;                        // Self-test failed
  logic r_sector_not_found_flag;                        // Data sector ID missing
  logic r_fault;                       // Device fault seen
  assign {nv_en_s, drive_id_s, r_done, r_fail, r_sector_not_found_flag, r_fault} = sync_b;

  // ==========================================
  // Decode helpers
  // True for the two self-tests that keep the host waiting
  function automatic logic is_captive(input logic [7:0] c);
    is_captive = (c == `HOEC_SUB_SHORT_CAP) || (c == `HOEC_SUB_EXT_CAP);
  endfunction
  // True for the routines that run behind a completed command
  function automatic logic is_offline(input logic [7:0] c);
    is_offline = (c == `HOEC_SUB_COLLECT) || (c == `HOEC_SUB_SHORT_OFF)
              || (c == `HOEC_SUB_EXT_OFF);
  endfunction

  // ==========================================
  // State
  hoec_state_t state;                  // Sequencer state
  hoec_state_t next_state;
  logic [7:0]  feature;                // Feature select
  logic [7:0]  seccnt;                 // Sector count
  logic [7:0]  subcmd;                 // Subcommand select
  logic [7:0]  sig_lo;                 // Signature low
  logic [7:0]  sig_hi;                 // Signature high
  logic [7:0]  drvsel;                 // Drive select
  logic [7:0]  dev_state;              // Status byte
  logic [7:0]  fault;                  // Error byte
  logic        mon_on;                 // Monitoring enabled
  logic        loaded;                 // Enable loaded after reset
  logic        offl_run;               // Off-line routine running
  logic [31:0] svc_cnt;                // Time left to stop routine
  logic        cmd_go;                 // Command write latched
  // Next values, one for each registered field
  logic [7:0]  next_feature, next_seccnt, next_subcmd, next_sig_lo, next_sig_hi;
  logic [7:0]  next_drvsel, next_dev_state, next_fault, next_rdata, next_code;
  logic        next_mon_on, next_loaded, next_offl_run, next_cmd_go;
  logic        next_nv_write, next_nv_value, next_start, next_stop;
  logic [31:0] next_svc_cnt;
  logic        selected;               // Command addressed to us
  logic        wr_cmd;                 // Command register written

  // Drive select decides whether a command write is ours
  assign selected = (drvsel[`HOEC_DRV_SEL] == drive_id_s);
  assign wr_cmd   = WR && (ADDR == `HOEC_ADDR_CMD) && selected;

  // ==========================================
  // Next-state computation
  always_comb begin
    // Defaults hold every register; pulses and read data fall back to zero
    next_state     = state;
    next_feature   = feature;
    next_seccnt    = seccnt;
    next_subcmd    = subcmd;
    next_sig_lo    = sig_lo;
    next_sig_hi    = sig_hi;
    next_drvsel    = drvsel;
    next_dev_state = dev_state;
    next_fault     = fault;
    next_mon_on    = mon_on;
    next_loaded    = loaded;
    next_offl_run  = offl_run;
    next_svc_cnt   = svc_cnt;
    next_cmd_go    = 1'b0;
    next_nv_write  = 1'b0;
    next_nv_value  = NV_VALUE;
    next_start     = 1'b0;
    next_stop      = 1'b0;
    next_code      = ROUTINE_CODE;
    next_rdata     = 8'h00;
    // Enable state restored from non-volatile store after reset
    if (!loaded) begin
      next_mon_on = nv_en_s;
      next_loaded = 1'b1;
    end
    // Register reads, one cycle later
    // Status reads zero while the other drive is addressed
    if (RD) begin
      unique case (ADDR)
        `HOEC_ADDR_FAULT:  next_rdata = fault;
        `HOEC_ADDR_SECCNT: next_rdata = seccnt;
        `HOEC_ADDR_SUBCMD: next_rdata = subcmd;
        `HOEC_ADDR_SIG_LO: next_rdata = sig_lo;
        `HOEC_ADDR_SIG_HI: next_rdata = sig_hi;
        `HOEC_ADDR_DRVSEL: next_rdata = drvsel;
        `HOEC_ADDR_STATE:  next_rdata = selected ? dev_state : 8'h00;
        default:           next_rdata = 8'h00;
      endcase
    end
    // Register writes, drive select included, are refused while busy
    if (WR && !dev_state[`HOEC_ST_BUSY]) begin
      unique case (ADDR)
        `HOEC_ADDR_FEATURE: next_feature = WDATA;
        `HOEC_ADDR_SECCNT:  next_seccnt  = WDATA;
        `HOEC_ADDR_SUBCMD:  next_subcmd  = WDATA;
        `HOEC_ADDR_SIG_LO:  next_sig_lo  = WDATA;
        `HOEC_ADDR_SIG_HI:  next_sig_hi  = WDATA;
        `HOEC_ADDR_DRVSEL:  next_drvsel  = WDATA;
        `HOEC_ADDR_CMD:     next_cmd_go  = wr_cmd;
        default:            next_cmd_go  = 1'b0;
      endcase
    end
    // Off-line routine watchdog: a new command addressed to this drive stops it in time
    if (offl_run) begin
      // Routine ended on its own; nothing to stop
      if (r_done) begin
        next_offl_run = 1'b0;
      end else if (svc_cnt != 32'h0) begin
        next_svc_cnt = svc_cnt - 32'h1;
        if (svc_cnt == 32'h1) begin
          // Stop pulse ends the routine in the engine
          next_stop     = 1'b1;
          next_offl_run = 1'b0;
        end
      end
    end
    unique case (state)
      HOEC_IDLE: begin
        if (cmd_go) begin
          next_dev_state = 8'h80;                                 // Busy while deciding
          next_state     = HOEC_DECODE;
          if (offl_run) begin
            next_svc_cnt = 32'h1;
          end
        end
      end
      HOEC_DECODE: begin
        next_fault = 8'h00;
        next_state = HOEC_DONE;
        // Default completion: ready, no request, no data phase
        next_dev_state = 8'h40;
        // Enable: a repeat enable leaves all monitoring state alone
        if (feature == `HOEC_FEAT_MON_ON && sig_lo == `HOEC_SIG_LO_OK
            && sig_hi == `HOEC_SIG_HI_OK) begin
          if (!mon_on) begin
            next_mon_on   = 1'b1;
            next_nv_write = 1'b1;
            next_nv_value = 1'b1;
          end
        end else if (feature == `HOEC_FEAT_MON_OFF && sig_lo == `HOEC_SIG_LO_OK
                     && sig_hi == `HOEC_SIG_HI_OK) begin
          // Disable: stop any routine and store the off state
          next_mon_on   = 1'b0;
          next_nv_write = 1'b1;
          next_nv_value = 1'b0;
          next_stop     = offl_run;
          next_offl_run = 1'b0;
        end else if (feature == `HOEC_FEAT_RUN_NOW && mon_on
                     && sig_lo == `HOEC_SIG_LO_OK && sig_hi == `HOEC_SIG_HI_OK
                     && (is_offline(subcmd) || is_captive(subcmd)
                         || subcmd == `HOEC_SUB_ABORT_OFF)) begin
          // Execute: the routine code follows the subcommand byte
          next_code = subcmd;
          // Captive: busy stands until the engine reports
          if (is_captive(subcmd)) begin
            next_dev_state = 8'hC0;
            next_start     = 1'b1;
            next_stop      = offl_run;
            next_offl_run  = 1'b0;
            next_state     = HOEC_CAPTIVE;
          end else if (subcmd == `HOEC_SUB_ABORT_OFF) begin
            // Abort of the off-line routine only, nothing started
            next_stop     = offl_run;
            next_offl_run = 1'b0;
          end else begin
            // Off-line: complete now, the routine runs behind ready
            next_start    = 1'b1;
            next_offl_run = 1'b1;
            next_svc_cnt  = 32'h0;
          end
        end else begin
          // Aborted: captive requests get the good signature loaded
          next_fault = 8'h04;
          next_dev_state = 8'h41;
          if (is_captive(subcmd)) begin
            next_sig_lo = `HOEC_SIG_LO_OK;
            next_sig_hi = `HOEC_SIG_HI_OK;
          end
        end
      end
      HOEC_CAPTIVE: begin
        if (r_done) begin
          next_state = HOEC_DONE;
          // Result flags from the engine fill error and status bytes
          next_fault = {3'h0, r_sector_not_found_flag, 1'b0, r_fail, 2'h0};
          next_dev_state = {1'b0, 1'b1, r_fault, 4'h0, r_fail | r_sector_not_found_flag};
          // A failed self-test returns the failure signature
          if (r_fail) begin
            next_sig_lo = `HOEC_SIG_LO_FAIL;
            next_sig_hi = `HOEC_SIG_HI_FAIL;
          end else begin
            next_sig_lo = `HOEC_SIG_LO_OK;
            next_sig_hi = `HOEC_SIG_HI_OK;
          end
        end
      end
      HOEC_DONE: begin
        // One settle cycle before the next command is taken
        next_state = HOEC_IDLE;
      end
      default: begin
        // Illegal one-hot code: recover to idle
        next_state = HOEC_IDLE;
      end
    endcase
    // Off-line ID fault reported as sticky sector-not-found
    if (offl_run && r_sector_not_found_flag) begin
      next_fault[`HOEC_ER_SECTOR_NOT_FOUND_FLAG]    = 1'b1;
      next_dev_state[`HOEC_ST_ERR] = 1'b1;
    end
  end

  // ==========================================
  // State registers
  // Reset leaves ready status and monitoring off until the enable loads
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state          <= HOEC_IDLE;
      feature        <= 8'h00;
      seccnt         <= 8'h00;
      subcmd         <= 8'h00;
      sig_lo         <= 8'h00;
      sig_hi         <= 8'h00;
      drvsel         <= 8'h00;
      dev_state      <= 8'h40;
      fault          <= 8'h00;
      mon_on         <= 1'b0;
      loaded         <= 1'b0;
      offl_run       <= 1'b0;
      svc_cnt        <= 32'h0;
      cmd_go         <= 1'b0;
      RDATA          <= 8'h00;
      NV_WRITE       <= 1'b0;
      NV_VALUE       <= 1'b0;
      ROUTINE_START  <= 1'b0;
      ROUTINE_CODE   <= 8'h00;
      ROUTINE_STOP   <= 1'b0;
      ROUTINE_ACTIVE <= 1'b0;
      MONITOR_ON     <= 1'b0;
    end else if (CE) begin
      // Every register holds while CE is low
      state          <= next_state;
      feature        <= next_feature;
      seccnt         <= next_seccnt;
      subcmd         <= next_subcmd;
      sig_lo         <= next_sig_lo;
      sig_hi         <= next_sig_hi;
      drvsel         <= next_drvsel;
      dev_state      <= next_dev_state;
      fault          <= next_fault;
      mon_on         <= next_mon_on;
      loaded         <= next_loaded;
      offl_run       <= next_offl_run;
      svc_cnt        <= next_svc_cnt;
      cmd_go         <= next_cmd_go;
      RDATA          <= next_rdata;
      NV_WRITE       <= next_nv_write;
      NV_VALUE       <= next_nv_value;
      ROUTINE_START  <= next_start;
      ROUTINE_CODE   <= next_code;
      ROUTINE_STOP   <= next_stop;
      ROUTINE_ACTIVE <= next_offl_run || (next_state == HOEC_CAPTIVE);
      MONITOR_ON     <= next_mon_on;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/hoec_cfg.svh */
// Constants for the health-monitoring command block
`ifndef HOEC_CFG_SVH
`define HOEC_CFG_SVH
// ==========================================
// Register indices on the task-file port
`define HOEC_ADDR_FEATURE     3'h1
`define HOEC_ADDR_SECCNT      3'h2
`define HOEC_ADDR_SUBCMD      3'h3
`define HOEC_ADDR_SIG_LO      3'h4
`define HOEC_ADDR_SIG_HI      3'h5
`define HOEC_ADDR_DRVSEL      3'h6
`define HOEC_ADDR_CMD         3'h7
`define HOEC_ADDR_STATE       3'h7
`define HOEC_ADDR_FAULT       3'h1
// ==========================================
// Command and feature codes
`define HOEC_OPC_HEALTH       8'hB0
`define HOEC_FEAT_RUN_NOW     8'hD4
`define HOEC_FEAT_MON_ON      8'hD8
`define HOEC_FEAT_MON_OFF     8'hD9
`define HOEC_SIG_LO_OK        8'h4F
`define HOEC_SIG_HI_OK        8'hC2
`define HOEC_SIG_LO_FAIL      8'hF4
`define HOEC_SIG_HI_FAIL      8'h2C
// ==========================================
// Subcommand codes
`define HOEC_SUB_COLLECT      8'h00
`define HOEC_SUB_SHORT_OFF    8'h01
`define HOEC_SUB_EXT_OFF      8'h02
`define HOEC_SUB_ABORT_OFF    8'h7F
`define HOEC_SUB_SHORT_CAP    8'h81
`define HOEC_SUB_EXT_CAP      8'h82
// ==========================================
// Bit positions
`define HOEC_ST_BUSY          7
`define HOEC_ST_DRIVE_READY_FLAG          6
`define HOEC_ST_DF            5
`define HOEC_ST_DRQ           3
`define HOEC_ST_ERR           0
`define HOEC_ER_SECTOR_NOT_FOUND_FLAG          4
`define HOEC_ER_ABORTED_COMMAND_FLAG          2
`define HOEC_DRV_SEL          4
// ==========================================
// Timing: service a new command within two seconds
`define HOEC_SERVICE_MS       2000
`define HOEC_CLK_MHZ          200
`define HOEC_SERVICE_CYC      (`HOEC_SERVICE_MS * 1000 * `HOEC_CLK_MHZ)
`endif

/* File: verilog/hoec_pkg.sv */
// Types for the health-monitoring command block
package hoec_pkg;
  // Command sequencer states, one-hot
  typedef enum logic [3:0] {
    HOEC_IDLE    = 4'b0001,
    HOEC_DECODE  = 4'b0010,
    HOEC_CAPTIVE = 4'b0100,
    HOEC_DONE    = 4'b1000
  } hoec_state_t;
endpackage

/* File: tb/hoec_chk.sv */
// Port assertions for the health command interpreter
`timescale 1ns/1ps
`default_nettype none
module hoec_chk (
  input wire logic       CLK,
  input wire logic       SRST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       NV_WRITE,
  input wire logic       ROUTINE_START,
  input wire logic [7:0] ROUTINE_CODE,
  input wire logic       ROUTINE_STOP,
  input wire logic       ROUTINE_ACTIVE,
  input wire logic       MONITOR_ON
);
  // ==========
  // Cycles since the last command write, saturating at 15
  logic [3:0] gap;
  logic [3:0] next_gap;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence cmd_s;
    WR && ADDR == 3'h7 && WDATA == 8'hB0;
  endsequence
  sequence offline_run_s;
    ROUTINE_ACTIVE && !ROUTINE_CODE[7];
  endsequence
  // Next count: restart on a command write
  always_comb begin
    next_gap = (gap == 4'hF) ? gap : gap + 4'h1;
    if (WR && ADDR == 3'h7 && WDATA == 8'hB0) next_gap = 4'h0;
  end
  // Count register
  always_ff @(posedge CLK) gap <= SRST ? 4'hF : next_gap;
  start_cause_a: assert property (ROUTINE_START |-> gap <= 4'h6)
    else $error("routine start without command");
  start_gate_a: assert property (ROUTINE_START |-> MONITOR_ON)
    else $error("routine start while monitoring off");
  start_code_a: assert property (ROUTINE_START |->
    ROUTINE_CODE inside {8'h00, 8'h01, 8'h02, 8'h7F, 8'h81, 8'h82})
    else $error("routine started with reserved code");
  start_pulse_a: assert property (ROUTINE_START |=> !ROUTINE_START)
    else $error("start longer than one cycle");
  run_flag_a: assert property (ROUTINE_START |-> ##[0:1] ROUTINE_ACTIVE)
    else $error("routine not marked active");
  offline_stop_a: assert property (offline_run_s ##0 cmd_s |-> ##[1:4] ROUTINE_STOP)
    else $error("off-line routine not stopped");
  nv_pulse_a: assert property (NV_WRITE |=> !NV_WRITE)
    else $error("store write longer than one cycle");
  rdata_idle_a: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data without read");
endmodule
bind hoec_cmd hoec_chk i_chk (.CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .NV_WRITE,
  .ROUTINE_START, .ROUTINE_CODE, .ROUTINE_STOP, .ROUTINE_ACTIVE, .MONITOR_ON);
`default_nettype wire

/* File: tb/hoec_model.sv */
// Routine engine and non-volatile enable store behind the block
`timescale 1ns/1ps
`default_nettype none
module hoec_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       start,
  input  wire logic [7:0] code,
  input  wire logic       stop,
  input  wire logic       active,
  input  wire logic       nv_write,
  input  wire logic       nv_value,
  input  wire logic       fail_req,
  input  wire logic       sector_not_found_flag_req,
  output logic            done,
  output logic            fail,
  output logic            sector_not_found_flag,
  output logic            nv_enable
);
  // ==========
  logic       run; // Routine in progress
  logic [4:0] cnt; // Captive cycles left
  // Enable bit is not touched by reset, like a flash cell
  initial begin
    nv_enable = 1'b0;
    done = 1'b0;
    fail = 1'b0;
  end
  always @(posedge clk) if (nv_write) nv_enable <= nv_value;
  assign sector_not_found_flag = run && sector_not_found_flag_req;
  // Captive runs end after a fixed wait; off-line runs only on stop.
  // A start beside a stop is a restart, so the start wins
  always @(posedge clk) begin
    if (srst) begin
      run <= 1'b0;
    end else if (start) begin
      run <= 1'b1;
      cnt <= 5'h14;
      done <= 1'b0;
      fail <= 1'b0;
    end else if (stop) begin
      run <= 1'b0;
    end else if (run && code[7]) begin
      cnt <= cnt - 5'h01;
      if (cnt == 5'h00) begin
        run <= 1'b0;
        done <= 1'b1;
        fail <= fail_req;
      end
    end else if (done && !active) begin
      done <= 1'b0; // Result taken, drop it
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the health command interpreter
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       fail_req = 1'b0;
  logic       sector_not_found_flag_req = 1'b0;
  logic [7:0] rdata, code, v, first;
  logic       nv_write, nv_value, start, stop, active, mon_on, done, fail, sector_not_found_flag, nv_en;
  int         failures = 0;
  int         checks_done = 0;
  int         cycles = 0;
  always #2.5 clk = ~clk;
  hoec_cmd #(.SERVICE_CYC(16)) i_dut (.CLK(clk), .SRST(srst), .CE(1'b1), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .DRIVE_ID(1'b0), .NV_ENABLE(nv_en),
    .NV_WRITE(nv_write), .NV_VALUE(nv_value), .ROUTINE_START(start), .ROUTINE_CODE(code),
    .ROUTINE_STOP(stop), .ROUTINE_ACTIVE(active), .MONITOR_ON(mon_on), .ROUTINE_DONE(done),
    .ROUTINE_FAIL(fail), .ROUTINE_SECTOR_NOT_FOUND_FLAG(sector_not_found_flag), .ROUTINE_FAULT(1'b0));
  hoec_model i_model (.clk(clk), .srst(srst), .start(start), .code(code), .stop(stop),
    .active(active), .nv_write(nv_write), .nv_value(nv_value), .fail_req(fail_req),
    .sector_not_found_flag_req(sector_not_found_flag_req), .done(done), .fail(fail), .sector_not_found_flag(sector_not_found_flag), .nv_enable(nv_en));
  // ==========
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [2:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic issue(input logic [7:0] feat, sub, lo, dsel);
    wreg(3'h6, dsel);
    wreg(3'h4, lo);
    wreg(3'h5, 8'hC2);
    wreg(3'h3, sub);
    wreg(3'h1, feat);
    wreg(3'h7, 8'hB0);
    repeat (3) @(posedge clk);
    rreg(3'h7);
    first = v;
    for (int i = 0; i < 100 && v[7] !== 1'b0; i++) rreg(3'h7);
  endtask
  task automatic do_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic t_disabled;
    issue(8'hD4, 8'h01, 8'h4F, 8'h00);
    chk(v, 8'h41, "abort while off");
    rreg(3'h1);
    chk(v, 8'h04, "abort flag");
    $display("test disabled done");
  endtask
  task automatic t_enable;
    for (int k = 0; k < 2; k++) begin
      issue(8'hD8, 8'h00, 8'h4F, 8'h00);
      chk(v, 8'h40, "enable");
    end
    do_reset();
    chk({7'h00, mon_on}, 8'h01, "enable kept over reset");
    $display("test enable done");
  endtask
  task automatic t_bad;
    issue(8'hD4, 8'h81, 8'h00, 8'h00);
    chk(v, 8'h41, "bad signature");
    rreg(3'h4);
    chk(v, 8'h4F, "captive abort low");
    rreg(3'h5);
    chk(v, 8'hC2, "captive abort high");
    issue(8'hD5, 8'h81, 8'h4F, 8'h00);
    chk(v, 8'h41, "bad feature");
    issue(8'hD4, 8'h03, 8'h4F, 8'h00);
    chk(v, 8'h41, "reserved code");
    issue(8'hD4, 8'h81, 8'h4F, 8'h10);
    chk(v, 8'h00, "other drive");
    $display("test bad input done");
  endtask
  task automatic t_captive(input logic f);
    fail_req <= f;
    issue(8'hD4, f ? 8'h82 : 8'h81, 8'h4F, 8'h00);
    chk(first, 8'hC0, "busy while captive");
    chk(v, f ? 8'h41 : 8'h40, "captive end");
    rreg(3'h1);
    chk(v, f ? 8'h04 : 8'h00, "captive error");
    rreg(3'h4);
    chk(v, f ? 8'hF4 : 8'h4F, "captive low");
    rreg(3'h5);
    chk(v, f ? 8'h2C : 8'hC2, "captive high");
    $display("test captive done");
  endtask
  task automatic t_offline;
    for (int k = 0; k < 3; k++) begin
      issue(8'hD4, k[7:0], 8'h4F, 8'h00);
      chk(first, 8'h40, "complete before routine");
      chk(code, k[7:0], "routine code");
      chk({7'h00, active}, 8'h01, "routine running");
    end
    sector_not_found_flag_req <= 1'b1;
    repeat (8) @(posedge clk);
    rreg(3'h1);
    chk(v & 8'h10, 8'h10, "id not found");
    rreg(3'h7);
    chk(v, 8'h41, "error flag");
    sector_not_found_flag_req <= 1'b0;
    issue(8'hD4, 8'h7F, 8'h4F, 8'h00);
    chk(v, 8'h40, "abort off-line");
    chk({7'h00, active}, 8'h00, "routine stopped");
    $display("test off-line done");
  endtask
  task automatic t_mon_off;
    issue(8'hD4, 8'h00, 8'h4F, 8'h00);
    chk({7'h00, active}, 8'h01, "routine before disable");
    issue(8'hD9, 8'h00, 8'h4F, 8'h00);
    chk(v, 8'h40, "disable");
    chk({6'h00, active, mon_on}, 8'h00, "disable stops routine");
    issue(8'hD4, 8'h01, 8'h4F, 8'h00);
    chk(v, 8'h41, "run after disable");
    $display("test disable done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    do_reset();
    t_disabled();
    t_enable();
    t_bad();
    t_captive(1'b0);
    t_captive(1'b1);
    t_offline();
    t_mon_off();
    test_done();
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
endmodule
`default_nettype wire
